// file: rtl/timer_v_defs.svh
`ifndef TIMER_V_DEFS_SVH
`define TIMER_V_DEFS_SVH

// output select codes
`define OSEL_NONE 2'h0
`define OSEL_LOW 2'h1
`define OSEL_HIGH 2'h2
`define OSEL_TOGGLE 2'h3

// clear select codes
`define CLR_NONE 2'h0
`define CLR_MATCH_A 2'h1
`define CLR_MATCH_B 2'h2
`define CLR_EXT_PIN 2'h3

// trigger edge codes
`define TRIG_OFF 2'h0
`define TRIG_RISE 2'h1
`define TRIG_FALL 2'h2
`define TRIG_BOTH 2'h3

// clock select: {internal_clock_sel_ext, clock_sel_bit2..0}
`define CKSEL_WIDTH 4
`define CKSEL_STOP 4'h0
`define CKSEL_EXT_RISE 4'h5
`define CKSEL_EXT_FALL 4'h6
`define CKSEL_EXT_BOTH 4'h7

// prescaler divide exponents for internal sources (default choices)
`define PRE_DIV_A 3'h1
`define PRE_DIV_B 3'h2
`define PRE_DIV_C 3'h3
`define PRE_DIV_D 3'h4
`define PRE_DIV_E 3'h5
`define PRE_DIV_F 3'h6
`define PRE_WIDTH 8

// reset values
`define COUNT_RESET 8'h00
`define COMPARE_RESET 8'hff

// least external clear pulse: 1.5 system clocks at 25 MHz (40 ns period)
`define CLEAR_PULSE_NS 60
`define CLK_PERIOD_NS 40
`define CLEAR_PULSE_CYCLES ((`CLEAR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: rtl/timer_v_pkg.sv
package timer_v_pkg;

    typedef struct packed {
        logic [1:0] outSelectB;
        logic [1:0] outSelectA;
        logic [1:0] clearSelect;
        logic [1:0] triggerEdge;
        logic triggerEnable;
        logic [3:0] clockSel;
        logic overflowIrqEnable;
        logic matchAIrqEnable;
        logic matchBIrqEnable;
    } timer_cfg_t;

    typedef struct packed {
        logic count;
        logic compareA;
        logic compareB;
    } write_strobe_t;

    typedef struct packed {
        logic overflow;
        logic matchA;
        logic matchB;
    } flag_bits_t;

    typedef enum logic [1:0] {
        RUN_IDLE = 2'b00,
        RUN_COUNT = 2'b01,
        RUN_WAIT_TRIGGER = 2'b10
    } run_state_t;

endpackage

// file: rtl/timer_v_edge_sync.sv
`include "timer_v_defs.svh"

module timer_v_edge_sync #(
    parameter int WIDTH = 3
)(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // raw pins
    input wire logic [WIDTH-1:0] pinIn,
    // synchronised levels and edges
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);

    logic [WIDTH-1:0] stageOne;
    logic [WIDTH-1:0] stageTwo;
    logic [WIDTH-1:0] stageThree;
    logic [WIDTH-1:0] next_stageOne;
    logic [WIDTH-1:0] next_stageTwo;
    logic [WIDTH-1:0] next_stageThree;

    always_comb
    begin
        next_stageOne = pinIn;
        next_stageTwo = stageOne;
        next_stageThree = stageTwo;
    end

    // stage one feeds only stage two
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stageOne <= '0;
            stageTwo <= '0;
            stageThree <= '0;
        end
        else
        begin
            stageOne <= next_stageOne;
            stageTwo <= next_stageTwo;
            stageThree <= next_stageThree;
        end
    end

    assign level = stageTwo;
    assign rise = stageTwo & ~stageThree;
    assign fall = ~stageTwo & stageThree;

endmodule // timer_v_edge_sync

// file: rtl/eight_bit_compare_timer.sv
// Notes on behaviour
// - counting starts once any of nine clock sources (six internal, three external) is selected
// - wrap ff to 00 sets overflow flag; interrupt if its enable set
// - counter compared with both compare values; equality sets matching flag
// - match pulse occurs in last cycle of equality, at the count tick
// - match interrupt raised when its enable and its flag are set
// - on match the output pin takes the level chosen by that select field
// - select codes: 00 hold, 01 low, 10 high, 11 toggle
// - output pin is 0 after reset until first match changes it
// - clear select 01 or 10 clears counter on match a or b
// - clear select 11: rising edge of clear pin clears; pulse 1.5 clocks
// - trigger enabled: clear halts counting until selected trigger edge arrives
// - trigger edge codes: 00 off, 01 rise, 10 fall, 11 both
// - flags clear by writing 0 after reading 1; only hardware sets them
// - clear coinciding with counter write wins; write discarded
// - increment coinciding with counter write loses; write wins
// - match coinciding with compare write suppressed; write completes
// - simultaneous matches: toggle over high over low
// - internal source increments on falling edge of divided clock
// - source switch high to low counts as falling edge, one extra increment
`include "timer_v_defs.svh"

module eight_bit_compare_timer #(
    parameter int COUNT_WIDTH = 8
)(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // configuration
    input wire timer_v_pkg::timer_cfg_t cfg,
    // software writes
    input wire timer_v_pkg::write_strobe_t writeStrobe,
    input wire logic [COUNT_WIDTH-1:0] writeData,
    // flag access: read marks armed, clear strobe writes 0
    input wire timer_v_pkg::flag_bits_t flagRead,
    input wire timer_v_pkg::flag_bits_t flagClear,
    // external pins
    input wire logic external_clock_pin,
    input wire logic external_clear_pin,
    input wire logic trigger_input_pin,
    // state
    output logic [COUNT_WIDTH-1:0] count_value,
    output logic [COUNT_WIDTH-1:0] compare_value_a,
    output logic [COUNT_WIDTH-1:0] compare_value_b,
    output logic overflow_flag,
    output logic match_flag_a,
    output logic match_flag_b,
    // requests and pin
    output logic overflowIrq,
    output logic matchAIrq,
    output logic matchBIrq,
    output logic timer_output_pin
);

    logic [2:0] pinLevel;
    logic [2:0] pinRise;
    logic [2:0] pinFall;

    timer_v_edge_sync #(.WIDTH(3)) pinSync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pinIn({trigger_input_pin, external_clear_pin, external_clock_pin}),
        .level(pinLevel),
        .rise(pinRise),
        .fall(pinFall)
    );

    // prescaler and tick source
    logic [`PRE_WIDTH-1:0] prescale;
    logic [`PRE_WIDTH-1:0] next_prescale;
    logic srcLevel;
    logic srcLevelPrev;
    logic next_srcLevelPrev;
    logic tick;

    function automatic logic prescaleBit(input logic [`PRE_WIDTH-1:0] pre, input logic [2:0] expo);
        prescaleBit = pre[expo - 3'h1];
    endfunction

    always_comb
    begin
        next_prescale = prescale + `PRE_WIDTH'(1);
        // internal sources use a divided clock level; falling edge counts
        case (cfg.clockSel)
            4'h1: srcLevel = prescaleBit(prescale, `PRE_DIV_A);
            4'h2: srcLevel = prescaleBit(prescale, `PRE_DIV_B);
            4'h3: srcLevel = prescaleBit(prescale, `PRE_DIV_C);
            4'h9: srcLevel = prescaleBit(prescale, `PRE_DIV_D);
            4'ha: srcLevel = prescaleBit(prescale, `PRE_DIV_E);
            4'hb: srcLevel = prescaleBit(prescale, `PRE_DIV_F);
            `CKSEL_EXT_RISE, `CKSEL_EXT_BOTH: srcLevel = ~pinLevel[0];
            `CKSEL_EXT_FALL: srcLevel = pinLevel[0];
            default: srcLevel = 1'b0;
        endcase
        next_srcLevelPrev = srcLevel;
        // a source switch from high to low is seen as a falling edge
        if (cfg.clockSel == `CKSEL_EXT_BOTH)
            tick = pinRise[0] | pinFall[0];
        else
            tick = srcLevelPrev & ~srcLevel;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            prescale <= '0;
            srcLevelPrev <= 1'b0;
        end
        else
        begin
            prescale <= next_prescale;
            srcLevelPrev <= next_srcLevelPrev;
        end
    end

    // counter, compares, run state
    timer_v_pkg::run_state_t runState;
    timer_v_pkg::run_state_t next_runState;
    logic [COUNT_WIDTH-1:0] next_count;
    logic [COUNT_WIDTH-1:0] next_compareA;
    logic [COUNT_WIDTH-1:0] next_compareB;
    logic countEnable;
    logic matchA;
    logic matchB;
    logic clearEvent;
    logic triggerEdge;
    logic wrapEvent;

    always_comb
    begin
        // match fires on the tick that ends equality, so it marks the last equal cycle
        countEnable = tick && (runState != timer_v_pkg::RUN_WAIT_TRIGGER);
        matchA = countEnable && (count_value == compare_value_a) && !writeStrobe.compareA;
        matchB = countEnable && (count_value == compare_value_b) && !writeStrobe.compareB;
        clearEvent = ((cfg.clearSelect == `CLR_MATCH_A) && matchA)
            || ((cfg.clearSelect == `CLR_MATCH_B) && matchB)
            || ((cfg.clearSelect == `CLR_EXT_PIN) && pinRise[1]);
        case (cfg.triggerEdge)
            `TRIG_RISE: triggerEdge = pinRise[2];
            `TRIG_FALL: triggerEdge = pinFall[2];
            `TRIG_BOTH: triggerEdge = pinRise[2] | pinFall[2];
            default: triggerEdge = 1'b0;
        endcase
        wrapEvent = countEnable && (count_value == {COUNT_WIDTH{1'b1}}) && !clearEvent && !writeStrobe.count;
        if (clearEvent)
            next_count = '0;
        else if (writeStrobe.count)
            next_count = writeData;
        else if (countEnable)
            next_count = count_value + COUNT_WIDTH'(1);
        else
            next_count = count_value;
        next_compareA = writeStrobe.compareA ? writeData : compare_value_a;
        next_compareB = writeStrobe.compareB ? writeData : compare_value_b;
        case (runState)
            timer_v_pkg::RUN_COUNT:
                next_runState = (clearEvent && cfg.triggerEnable) ? timer_v_pkg::RUN_WAIT_TRIGGER
                    : timer_v_pkg::RUN_COUNT;
            timer_v_pkg::RUN_WAIT_TRIGGER:
                next_runState = (!cfg.triggerEnable || triggerEdge) ? timer_v_pkg::RUN_COUNT
                    : timer_v_pkg::RUN_WAIT_TRIGGER;
            default:
                next_runState = timer_v_pkg::RUN_COUNT;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            runState <= timer_v_pkg::RUN_IDLE;
            count_value <= `COUNT_RESET;
            compare_value_a <= `COMPARE_RESET;
            compare_value_b <= `COMPARE_RESET;
        end
        else
        begin
            runState <= next_runState;
            count_value <= next_count;
            compare_value_a <= next_compareA;
            compare_value_b <= next_compareB;
        end
    end

    // flags with read-then-write-zero clearing; a set wins over a clear
    timer_v_pkg::flag_bits_t armed;
    timer_v_pkg::flag_bits_t next_armed;
    logic next_overflowFlag;
    logic next_matchFlagA;
    logic next_matchFlagB;

    function automatic logic flagNext(input logic cur, input logic set, input logic armedBit, input logic clr);
        flagNext = set | (cur & ~(armedBit & clr));
    endfunction

    always_comb
    begin
        next_overflowFlag = flagNext(overflow_flag, wrapEvent, armed.overflow, flagClear.overflow);
        next_matchFlagA = flagNext(match_flag_a, matchA, armed.matchA, flagClear.matchA);
        next_matchFlagB = flagNext(match_flag_b, matchB, armed.matchB, flagClear.matchB);
        // arming is lost by any clear attempt, so a stale read cannot clear a new event
        next_armed.overflow = (flagRead.overflow & overflow_flag) | (armed.overflow & ~flagClear.overflow);
        next_armed.matchA = (flagRead.matchA & match_flag_a) | (armed.matchA & ~flagClear.matchA);
        next_armed.matchB = (flagRead.matchB & match_flag_b) | (armed.matchB & ~flagClear.matchB);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            overflow_flag <= 1'b0;
            match_flag_a <= 1'b0;
            match_flag_b <= 1'b0;
            armed <= '0;
        end
        else
        begin
            overflow_flag <= next_overflowFlag;
            match_flag_a <= next_matchFlagA;
            match_flag_b <= next_matchFlagB;
            armed <= next_armed;
        end
    end

    assign overflowIrq = overflow_flag & cfg.overflowIrqEnable;
    assign matchAIrq = match_flag_a & cfg.matchAIrqEnable;
    assign matchBIrq = match_flag_b & cfg.matchBIrqEnable;

    // output pin
    logic next_outPin;
    logic [1:0] actA;
    logic [1:0] actB;
    logic [1:0] action;

    always_comb
    begin
        actA = matchA ? cfg.outSelectA : `OSEL_NONE;
        actB = matchB ? cfg.outSelectB : `OSEL_NONE;
        // codes rank in numeric order: toggle, high, low
        action = (actA > actB) ? actA : actB;
        case (action)
            `OSEL_LOW: next_outPin = 1'b0;
            `OSEL_HIGH: next_outPin = 1'b1;
            `OSEL_TOGGLE: next_outPin = ~timer_output_pin;
            default: next_outPin = timer_output_pin;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            timer_output_pin <= 1'b0;
        else
            timer_output_pin <= next_outPin;
    end

endmodule // eight_bit_compare_timer

// file: testbench/timer_chk.sv
module timer_chk #(
    parameter int COUNT_WIDTH = 8
)(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // stimulus seen
    input wire timer_v_pkg::timer_cfg_t cfg,
    input wire timer_v_pkg::write_strobe_t writeStrobe,
    input wire logic [COUNT_WIDTH-1:0] writeData,
    input wire timer_v_pkg::flag_bits_t flagClear,
    // outputs watched
    input wire logic [COUNT_WIDTH-1:0] count_value,
    input wire logic [COUNT_WIDTH-1:0] compare_value_a,
    input wire logic overflow_flag,
    input wire logic match_flag_a,
    input wire logic overflowIrq,
    input wire logic matchAIrq,
    input wire logic timer_output_pin
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    property p_ovf_irq;
        overflowIrq == (overflow_flag & cfg.overflowIrqEnable);
    endproperty
    a_ovf_irq: assert property (p_ovf_irq)
        else $error("overflow request wrong");
    property p_ovf_wrap;
        $rose(overflow_flag) |-> count_value == '0;
    endproperty
    a_ovf_wrap: assert property (p_ovf_wrap)
        else $error("overflow without wrap");
    property p_ma_irq;
        matchAIrq == (match_flag_a & cfg.matchAIrqEnable);
    endproperty
    a_ma_irq: assert property (p_ma_irq)
        else $error("match a request wrong");
    property p_ma_set;
        $rose(match_flag_a) |-> $past(count_value) == $past(compare_value_a);
    endproperty
    a_ma_set: assert property (p_ma_set)
        else $error("match a set without equality");
    // a stuck clear path would leave the counter one past the match value
    property p_clr_a;
        $rose(match_flag_a) && cfg.clearSelect == 2'h1 |-> count_value == '0;
    endproperty
    a_clr_a: assert property (p_clr_a)
        else $error("match a did not clear counter");
    property p_ovf_hold;
        $fell(overflow_flag) |-> $past(flagClear.overflow);
    endproperty
    a_ovf_hold: assert property (p_ovf_hold)
        else $error("overflow flag dropped by itself");
    property p_cnt_wr;
        writeStrobe.count && cfg.clearSelect == 2'h0 |=> count_value == $past(writeData);
    endproperty
    a_cnt_wr: assert property (p_cnt_wr)
        else $error("counter write lost");
    property p_cmpa_wr;
        writeStrobe.compareA |=> compare_value_a == $past(writeData);
    endproperty
    a_cmpa_wr: assert property (p_cmpa_wr)
        else $error("compare a write lost");
    property p_stop;
        cfg.clockSel == 4'h0 && $past(cfg.clockSel) == 4'h0 && cfg.clearSelect == 2'h0
            && !writeStrobe.count |=> $stable(count_value);
    endproperty
    a_stop: assert property (p_stop)
        else $error("counter moved with no source");
    property p_pin_hold;
        cfg.outSelectA == 2'h0 && cfg.outSelectB == 2'h0 |=> $stable(timer_output_pin);
    endproperty
    a_pin_hold: assert property (p_pin_hold)
        else $error("pin moved with no action selected");
endmodule // timer_chk

bind eight_bit_compare_timer timer_chk #(.COUNT_WIDTH(COUNT_WIDTH)) timer_chk_inst (.clk, .sys_rst, .cfg,
    .writeStrobe, .writeData, .flagClear, .count_value, .compare_value_a, .overflow_flag, .match_flag_a,
    .overflowIrq, .matchAIrq, .timer_output_pin);

// file: testbench/pin_model.sv
module pin_model (
    // clock
    input wire logic clk,
    // pins toward the timer, low and still while idle
    output logic extClk,
    output logic extClr,
    output logic trig
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        extClk = 1'b0;
        extClr = 1'b0;
        trig = 1'b0;
    end
    task automatic drive(input int which, input logic v);
        if (which == 0)
            extClk <= v;
        else if (which == 1)
            extClr <= v;
        else
            trig <= v;
    endtask
    task automatic pulse(input int which);
        @(posedge clk);
        drive(which, 1'b1);
        repeat (3) @(posedge clk); // held well over the least width
        drive(which, 1'b0);
        // room for the two-flop sync before the next edge
        repeat (4) @(posedge clk);
    endtask
endmodule // pin_model

// file: testbench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    timer_v_pkg::timer_cfg_t cfg;
    timer_v_pkg::write_strobe_t writeStrobe;
    timer_v_pkg::flag_bits_t flagRead;
    timer_v_pkg::flag_bits_t flagClear;
    logic [7:0] writeData;
    logic extClk, extClr, trig;
    logic [7:0] count_value, compare_value_a, compare_value_b;
    logic overflow_flag, match_flag_a, match_flag_b, overflowIrq, matchAIrq, matchBIrq, timer_output_pin;
    logic [31:0] expQ[$];
    logic [31:0] cur;
    logic [15:0] got;
    logic probe = 1'b0;
    logic pinModel = 1'b0;
    // last entry is the free pulse setup: set on a, reset on b, clear on a
    logic [1:0] sa [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h3, 2'h2, 2'h2};
    logic [1:0] sb [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h3, 2'h1};
    logic [1:0] code;
    logic [7:0] r;
    int nErrors = 0;
    int compares = 0;
    int i;

    always #20 clk = ~clk;

    eight_bit_compare_timer #(.COUNT_WIDTH(8)) eight_bit_compare_timer_inst (.clk, .sys_rst, .cfg, .writeStrobe,
        .writeData, .flagRead, .flagClear, .external_clock_pin(extClk), .external_clear_pin(extClr),
        .trigger_input_pin(trig), .count_value, .compare_value_a, .compare_value_b, .overflow_flag,
        .match_flag_a, .match_flag_b, .overflowIrq, .matchAIrq, .matchBIrq, .timer_output_pin);
    pin_model pin_model_inst (.clk, .extClk, .extClr, .trig);

    task automatic endSim;
        if (nErrors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input int which, input logic [7:0] d);
        @(posedge clk);
        writeData <= d;
        writeStrobe <= timer_v_pkg::write_strobe_t'(3'h4 >> which);
        @(posedge clk);
        writeStrobe <= '0;
    endtask
    task automatic fl(input logic rd);
        @(posedge clk);
        if (rd)
            flagRead <= '1;
        else
            flagClear <= '1;
        @(posedge clk);
        flagRead <= '0;
        flagClear <= '0;
    endtask
    // mask first, so bits left open by a scenario never count
    task automatic want(input logic [15:0] m, input logic [15:0] e);
        expQ.push_back({m, e});
        @(posedge clk);
        probe <= 1'b1;
        @(posedge clk);
        probe <= 1'b0;
    endtask

    always @(posedge clk)
    begin
        if (probe)
        begin
            cur = expQ.pop_front();
            got = {matchBIrq, match_flag_b, 1'b0, overflowIrq, overflow_flag, matchAIrq, timer_output_pin,
                match_flag_a, count_value};
            compares++;
            if (((got ^ cur[15:0]) & cur[31:16]) !== 16'h0000)
            begin
                nErrors++;
                $display("Error %0t exp %h got %h", $time, cur[15:0], got);
            end
        end
    end

    initial
    begin
        cfg <= '0;
        writeStrobe <= '0;
        flagRead <= '0;
        flagClear <= '0;
        writeData <= 8'h00;
        void'($urandom(32'h43a7));
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        want(16'hffff, 16'h0000);
        cfg.clockSel <= 4'h1;
        cfg.overflowIrqEnable <= 1'b1;
        cfg.matchAIrqEnable <= 1'b1;
        cfg.matchBIrqEnable <= 1'b1;
        wr(0, 8'hfe);
        for (i = 0; i < 40 && overflow_flag !== 1'b1; i++)
            @(posedge clk);
        want(16'hdf00, 16'hdd00);
        fl(1'b0);
        want(16'hdf00, 16'hdd00);
        fl(1'b1);
        fl(1'b0);
        want(16'hdd00, 16'h0000);
        cfg.clockSel <= 4'h5;
        cfg.clearSelect <= 2'h1;
        repeat (4) @(posedge clk);
        for (i = 0; i < 8; i++)
        begin
            cfg.outSelectA <= sa[i];
            cfg.outSelectB <= sb[i];
            r = 8'h02 + 8'($urandom % 240);
            wr(1, r);
            wr(2, r);
            wr(0, r);
            pin_model_inst.pulse(0);
            code = (sa[i] > sb[i]) ? sa[i] : sb[i];
            if (code == 2'h1)
                pinModel = 1'b0;
            else if (code == 2'h2)
                pinModel = 1'b1;
            else if (code == 2'h3)
                pinModel = ~pinModel;
            want(16'hc3ff, {2'h3, 4'h0, pinModel, 1'b1, 8'h00});
        end
        cfg.clearSelect <= 2'h3;
        wr(0, 8'h40);
        pin_model_inst.pulse(1);
        want(16'h00ff, 16'h0000);
        cfg.triggerEnable <= 1'b1;
        for (i = 0; i < 4; i++)
        begin
            cfg.triggerEdge <= 2'(i);
            pin_model_inst.pulse(1);
            pin_model_inst.pulse(0);
            want(16'h00ff, 16'h0000);
            pin_model_inst.pulse(2);
            pin_model_inst.pulse(0);
            want(16'h00ff, {15'h0000, i != 0});
        end
        cfg.triggerEnable <= 1'b0;
        cfg.clockSel <= 4'h0;
        cfg.clearSelect <= 2'h0;
        repeat (4) @(posedge clk);
        wr(0, 8'h77);
        pin_model_inst.pulse(0);
        want(16'h00ff, 16'h0077);
        endSim();
    end

    initial
    begin
        repeat (4000) @(posedge clk);
        nErrors++;
        endSim();
    end
endmodule // testbench
